/* dv/sbsc_host_model.sv */
// Host side model: processor and cache controller pins of the device.
// Assumes the bench calls drv once a cycle; it waits for the falling edge.
`timescale 1ns/1ns
`default_nettype none
module sbsc_host_model (
    // Clock
    input  wire logic   clk_sys_i,
    // Pins toward the device
    output logic [5:0]  ctl_o,
    output logic [3:0]  wr_o,
    output logic [16:0] addr_o,
    output logic [17:0] dat_o,
    output logic        oe_n_o,
    output logic        mode_o,
    output logic        snz_o
);
    // ctl_o is {sel1_n, sel2, sel3_n, proc_n, ctrl_n, adv_n}; start deselected
    initial begin
        ctl_o  = 6'h2D;
        wr_o   = 4'hF;
        addr_o = 17'h0_0000;
        dat_o  = 18'h0_0000;
        oe_n_o = 1'b1;
        mode_o = 1'b1;
        snz_o  = 1'b0;
    end

    task automatic drv(input logic [5:0] c, input logic [3:0] w, input logic [16:0] a,
                       input logic [17:0] d, input logic oe, input logic m, input logic z);
        logic wc;
        wc = !w[3] || (!w[2] && w[1:0] != 2'h3);
        @(negedge clk_sys_i);
        ctl_o  = c;
        wr_o   = w;
        addr_o = a;
        mode_o = m;
        snz_o  = z;
        // Output enable released before any write data is driven
        oe_n_o = oe | wc;
        // Idle data lines never repeat the last value
        dat_o  = wc ? d : ~dat_o;
    endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the burst SRAM cycle control core.
// Assumes sbsc_host_model drives all pins but clock and reset; a queue-free model tracks the array.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import sbsc_pkg::*;
    logic        clk_sys_i, rstn_i, oe_n, mode, snz, oen_n, snzg, m;
    logic [5:0]  ctl;
    logic [3:0]  wr;
    logic [16:0] adr, aa, ma, pma, rnd, base;
    logic [17:0] dat;
    logic [15:0] dq;
    logic [1:0]  dp, s0;
    logic [17:0] mem [int];
    int          err_total, cmp_count, st, pst, bc, i;
    logic [5:0]  desel [3] = '{6'h05, 6'h1D, 6'h03};

    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    sbsc_host_model sbsc_host_model_i (.clk_sys_i(clk_sys_i), .ctl_o(ctl), .wr_o(wr),
        .addr_o(adr), .dat_o(dat), .oe_n_o(oe_n), .mode_o(mode), .snz_o(snz));
    sbsc_core sbsc_core_i (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(adr),
        .proc_addr_strobe_n_i(ctl[2]), .ctrl_addr_strobe_n_i(ctl[1]),
        .burst_advance_n_i(ctl[0]), .chip_sel_one_n_i(ctl[5]), .chip_sel_two_i(ctl[4]),
        .chip_sel_three_n_i(ctl[3]), .global_wr_n_i(wr[3]), .lane_wr_en_n_i(wr[2]),
        .lane_sel_n_i(wr[1:0]), .burst_interleave_i(mode), .snooze_req_i(snz),
        .out_en_n_i(oe_n), .data_in_i(dat[15:0]), .parity_io_in_i(dat[17:16]),
        .data_out_o(dq), .parity_io_out_o(dp), .data_oen_n_o(oen_n),
        .snoozing_o(snzg), .array_addr_o(aa));

    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction

    task automatic cv(input string n, input logic [17:0] e, input logic [17:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask

    // Model step at the rising edge, from the sampled pins
    task automatic upd;
        logic        sel, wc;
        logic [17:0] mk;
        sel = !ctl[5] && ctl[4] && !ctl[3];
        wc  = !wr[3] || (!wr[2] && wr[1:0] != 2'h3);
        mk  = !wr[3] ? 18'h3_FFFF : {~wr[1:0], {8{~wr[1]}}, {8{~wr[0]}}};
        pst = st;
        pma = ma;
        if (snz) st = 0;
        else if (!ctl[2] && !ctl[5]) begin
            st = sel;
            ma = adr;
            s0 = adr[1:0];
            bc = 0;
        end else if (!ctl[1]) begin
            st = sel ? (wc ? 2 : 1) : 0;
            ma = adr;
            s0 = adr[1:0];
            bc = 0;
        end else if (st != 0) begin
            if (!ctl[0]) begin
                bc++;
                ma[1:0] = mode ? s0 ^ bc[1:0] : ma[1:0] + 2'h1;
            end
            st = wc ? 2 : 1;
        end
        if (st == 2) mem[ma] = ((mem.exists(ma) ? mem[ma] : 18'h0_0000) & ~mk) | (dat & mk);
    endtask

    task automatic cyc(input logic [5:0] c, input logic [3:0] w, input logic [16:0] a,
                       input logic z);
        rnd = lfsr(rnd);
        sbsc_host_model_i.drv(c, w, a, {rnd, rnd[16]}, rnd[3], m, z);
        #9;
        if (st != 0) cv("array_addr", {1'b0, ma}, {1'b0, aa});
        if (st == 2) cv("oen_write", 18'h1, {17'h0, oen_n});
        if (st == 0 && pst == 0) cv("oen_idle", 18'h1, {17'h0, oen_n});
        if (st == 1 && pst == 1 && mem.exists(pma)) begin
            cv("read_word", mem[pma], {dp, dq});
            cv("oen_read", {17'h0, oe_n}, {17'h0, oen_n});
        end
        @(posedge clk_sys_i);
        upd();
    endtask

    task automatic rd(input logic [16:0] a, input logic both);
        cyc(both ? 6'h11 : 6'h13, rnd[3:0], a, 1'b0);
        repeat (3) cyc({1'b1, rnd[5:4], rnd[6], 2'b10}, 4'hF, 17'h0_0000, 1'b0);
        cyc(6'h2F, 4'hF, 17'h0_0000, 1'b0);
        cyc(6'h2D, 4'hF, 17'h0_0000, 1'b0);
    endtask

    task automatic finish_test;
        if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #100000;
        err_total++;
        finish_test();
    end

    initial begin
        rstn_i = 1'b0;
        m = 1'b1;
        rnd = 17'h1_37B1;
        st = 0;
        pst = 0;
        ma = 17'h0_0000;
        err_total = 0;
        cmp_count = 0;
        repeat (5) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rstn_i = 1'b1;
        base = rnd & 17'h1_FFFC;
        for (i = 0; i < 4; i++) cyc(6'h15, 4'h7, base + i, 1'b0);
        cyc(6'h13, rnd[3:0], base + 1, 1'b0);
        cyc(6'h2F, 4'hA, 17'h0_0000, 1'b0);
        cyc(6'h2F, 4'h9, 17'h0_0000, 1'b0);
        cyc(6'h15, 4'hF, base + 1, 1'b0);
        cyc(6'h2F, 4'hF, 17'h0_0000, 1'b0);
        for (i = 0; i < 8; i++) begin
            m = i[2];
            rd(base + i[1:0], i[0]);
        end
        for (i = 0; i < 3; i++) cyc(desel[i], 4'hF, base, 1'b0);
        cyc(6'h2D, 4'hF, 17'h0_0000, 1'b0);
        repeat (3) cyc(6'h2D, 4'hF, 17'h0_0000, 1'b1);
        #1 cv("snoozing", 18'h1, {17'h0, snzg});
        repeat (4) cyc(6'h2D, 4'hF, 17'h0_0000, 1'b0);
        #1 cv("snoozing", 18'h0, {17'h0, snzg});
        rd(base + 2, 1'b0);
        finish_test();
    end
endmodule
`default_nettype wire

/* src/sbsc_burst_cnt.sv */
// Two-bit wrap-around burst sequencer.
// Assumes caller supplies load and step qualifiers on the system clock.
`timescale 1ns/1ns
`default_nettype none
module sbsc_burst_cnt
    import sbsc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    // Control
    input  wire logic       load_i,
    input  wire logic       step_i,
    input  wire logic       interleave_i,
    input  wire logic [1:0] start_i,
    // Result
    output logic [1:0]      low_addr_o
);
    logic [1:0] base_r;
    logic [1:0] step_r;
    logic       mode_r;

    // Order is frozen at load so a mode pin change mid-burst cannot jump the address
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            base_r <= SBSC_CNT_RST;
            step_r <= SBSC_CNT_RST;
            mode_r <= 1'h1;
        end else if (load_i) begin
            base_r <= start_i;
            step_r <= SBSC_CNT_RST;
            mode_r <= interleave_i;
        end else if (step_i) begin
            step_r <= step_r + 2'h1;
        end
    end

    // Interleaved XORs the step count, linear adds modulo four
    always_comb begin
        if (mode_r) begin
            low_addr_o = base_r ^ step_r;
        end else begin
            low_addr_o = base_r + step_r;
        end
    end
endmodule
`default_nettype wire

/* src/sbsc_core.sv */
// Cycle decoder, address register and data path of a 128K x 18 burst SRAM.
// Assumes inputs synchronous to clk_sys_i; the array is flip-flop storage.
`timescale 1ns/1ns
`default_nettype none
module sbsc_core
    import sbsc_pkg::*;
#(
    parameter int ADDR_W = SBSC_ADDR_W,
    parameter int DEPTH  = SBSC_DEPTH
) (
    // Clock and reset
    input  wire logic                   clk_sys_i,
    input  wire logic                   rstn_i,
    // Address and strobes
    input  wire logic [ADDR_W-1:0]      addr_i,
    input  wire logic                   proc_addr_strobe_n_i,
    input  wire logic                   ctrl_addr_strobe_n_i,
    input  wire logic                   burst_advance_n_i,
    // Chip selects
    input  wire logic                   chip_sel_one_n_i,
    input  wire logic                   chip_sel_two_i,
    input  wire logic                   chip_sel_three_n_i,
    // Write controls
    input  wire logic                   global_wr_n_i,
    input  wire logic                   lane_wr_en_n_i,
    input  wire logic [1:0]             lane_sel_n_i,
    // Mode, power and output enable
    input  wire logic                   burst_interleave_i,
    input  wire logic                   snooze_req_i,
    input  wire logic                   out_en_n_i,
    // Data pins, split into in, out and enable
    input  wire logic [SBSC_DATA_W-1:0] data_in_i,
    input  wire logic [SBSC_PAR_W-1:0]  parity_io_in_i,
    output logic [SBSC_DATA_W-1:0]      data_out_o,
    output logic [SBSC_PAR_W-1:0]       parity_io_out_o,
    output logic                        data_oen_n_o,
    // Status
    output logic                        snoozing_o,
    output logic [ADDR_W-1:0]           array_addr_o
);
    localparam int WORD_W = SBSC_DATA_W + SBSC_PAR_W;

    logic [WORD_W-1:0] mem_r [DEPTH];
    logic [ADDR_W-1:0] addr_r;
    sbsc_cyc_t         cyc_r;
    sbsc_cyc_t         cyc_nxt;
    logic [1:0]        snz_r;
    logic              snz_act;
    logic              sel_all;
    logic              proc_go;
    logic              ctrl_go;
    logic              deselect;
    logic              any_wr;
    logic              load;
    logic              step;
    logic [1:0]        low_addr;
    logic [ADDR_W-1:0] cur_addr;
    logic [WORD_W-1:0] rd_word_r;
    logic              drive_r;
    logic [WORD_W-1:0] wr_word;
    logic [WORD_W-1:0] wr_mask;

    assign sel_all  = !chip_sel_one_n_i && chip_sel_two_i && !chip_sel_three_n_i;
    // Processor strobe gated by chip select one only
    assign proc_go  = !snz_act && !chip_sel_one_n_i && !proc_addr_strobe_n_i;
    // Processor strobe ignored with chip select one high, so controller strobe counts then
    assign ctrl_go  = !snz_act && !proc_go && !ctrl_addr_strobe_n_i;
    assign deselect = (proc_go || ctrl_go) && !sel_all;
    assign load     = (proc_go || ctrl_go) && sel_all;
    assign any_wr   = !global_wr_n_i || (!lane_wr_en_n_i && (lane_sel_n_i != 2'b11));
    // Strobe absent means burst continuation
    assign step     = !snz_act && !proc_go && !ctrl_go && !burst_advance_n_i
                      && cyc_r != SBSC_IDLE;

    // Snooze takes two clocks each way; entry aborts the current cycle
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            snz_r <= SBSC_SNZ_RST;
        end else begin
            snz_r <= {snz_r[0], snooze_req_i};
        end
    end
    assign snz_act = snz_r[1] || snooze_req_i;

    always_comb begin
        cyc_nxt = cyc_r;
        if (snz_act || deselect) begin
            cyc_nxt = SBSC_IDLE;
        end else if (proc_go && sel_all) begin
            cyc_nxt = SBSC_READ;
        end else if (ctrl_go && sel_all) begin
            cyc_nxt = any_wr ? SBSC_WRITE : SBSC_READ;
        end else if (cyc_r != SBSC_IDLE) begin
            cyc_nxt = any_wr ? SBSC_WRITE : SBSC_READ;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cyc_r <= SBSC_IDLE;
        end else begin
            cyc_r <= cyc_nxt;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            addr_r <= SBSC_ADDR_RST;
        end else if (load) begin
            addr_r <= addr_i;
        end
    end

    sbsc_burst_cnt u_cnt (
        .clk_sys_i    (clk_sys_i),
        .rstn_i       (rstn_i),
        .load_i       (load),
        .step_i       (step),
        .interleave_i (burst_interleave_i),
        .start_i      (addr_i[1:0]),
        .low_addr_o   (low_addr)
    );

    // Array address: upper bits from register, low from counter
    assign cur_addr = {addr_r[ADDR_W-1:2], low_addr};

    // Byte lanes with parity; global write covers all bits
    always_comb begin
        wr_mask = '0;
        if (!global_wr_n_i) begin
            wr_mask = '1;
        end else if (!lane_wr_en_n_i) begin
            wr_mask[SBSC_LANE0_LO +: SBSC_LANE_W] = {SBSC_LANE_W{!lane_sel_n_i[0]}};
            wr_mask[SBSC_LANE1_LO +: SBSC_LANE_W] = {SBSC_LANE_W{!lane_sel_n_i[1]}};
            wr_mask[SBSC_DATA_W]                  = !lane_sel_n_i[0];
            wr_mask[SBSC_DATA_W+1]                = !lane_sel_n_i[1];
        end
    end
    assign wr_word = {parity_io_in_i, data_in_i};

    // Write decided at one edge lands at the next, at the settled array address;
    // this way a loaded or stepped burst writes where the counter now points
    logic              wr_pend_r;
    logic [WORD_W-1:0] wr_mask_r;
    logic [WORD_W-1:0] wr_word_r;
    logic [WORD_W-1:0] rd_src;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_pend_r <= 1'b0;
            wr_mask_r <= '0;
            wr_word_r <= '0;
        end else begin
            wr_pend_r <= (cyc_nxt == SBSC_WRITE);
            wr_mask_r <= wr_mask;
            wr_word_r <= wr_word;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (wr_pend_r) begin
            for (int b = 0; b < WORD_W; b++) begin
                if (wr_mask_r[b]) begin
                    mem_r[cur_addr][b] <= wr_word_r[b];
                end
            end
        end
    end

    // Bypass so a read right after a write sees the new word
    always_comb begin
        rd_src = mem_r[cur_addr];
        if (wr_pend_r) begin
            rd_src = (rd_src & ~wr_mask_r) | (wr_word_r & wr_mask_r);
        end
    end

    // Read word registered after the address settles
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_word_r <= '0;
            drive_r   <= 1'b0;
        end else begin
            rd_word_r <= rd_src;
            drive_r   <= (cyc_r == SBSC_READ) && !snz_act;
        end
    end

    assign data_out_o      = rd_word_r[SBSC_DATA_W-1:0];
    assign parity_io_out_o = rd_word_r[WORD_W-1:SBSC_DATA_W];
    // Enable is combinational on out_en_n_i; writes never drive
    assign data_oen_n_o = !(drive_r && (cyc_r == SBSC_READ) && !out_en_n_i);
    assign snoozing_o   = snz_r[1];
    assign array_addr_o = cur_addr;

    a_ctrl_wr_start: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (sel_all && ctrl_go && any_wr && !snz_act) |=> cyc_r == SBSC_WRITE)
        else $error("controller write start missed");
    a_proc_read: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (sel_all && proc_go) |=> cyc_r == SBSC_READ && addr_r == $past(addr_i))
        else $error("processor start not a read");
    a_ctrl_read: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (sel_all && ctrl_go && !any_wr) |=> cyc_r == SBSC_READ)
        else $error("controller read start missed");
    a_desel_float: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        deselect |=> cyc_r == SBSC_IDLE && data_oen_n_o)
        else $error("deselect did not float data");
    a_wr_no_drive: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        cyc_r == SBSC_WRITE |-> data_oen_n_o)
        else $error("data driven during write");
    a_oe_float: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        out_en_n_i |-> data_oen_n_o)
        else $error("data driven with output enable high");
    a_snooze_idle: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        snooze_req_i ##1 snooze_req_i |=> cyc_r == SBSC_IDLE && snoozing_o)
        else $error("snooze not entered in two clocks");
    a_hold_addr: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (!load && !step && !snz_act) |=> $stable(array_addr_o))
        else $error("address moved while suspended");
    a_both_strobes: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (sel_all && !proc_addr_strobe_n_i && !ctrl_addr_strobe_n_i && !snz_act)
        |=> cyc_r == SBSC_READ)
        else $error("controller strobe not ignored");

    sequence s_sel_start;
        sel_all && (proc_go || ctrl_go);
    endsequence
    sequence s_addr_taken;
        addr_r == $past(addr_i) && cur_addr[1:0] == $past(addr_i[1:0]);
    endsequence
    a_start_capture: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        s_sel_start |=> s_addr_taken)
        else $error("start address not captured");
    a_gw_all: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        !global_wr_n_i |-> (&wr_mask))
        else $error("global write mask incomplete");
    a_lane_zero: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (global_wr_n_i && !lane_wr_en_n_i && !lane_sel_n_i[0])
        |-> (wr_mask[7:0] == 8'hFF) && wr_mask[SBSC_DATA_W])
        else $error("lane zero mask wrong");
    a_oe_drive: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (drive_r && cyc_r == SBSC_READ && !out_en_n_i) |-> !data_oen_n_o)
        else $error("read data not driven");
    a_ce1_ignore: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (chip_sel_one_n_i && !proc_addr_strobe_n_i && !ctrl_addr_strobe_n_i && !snz_act)
        |=> cyc_r == SBSC_IDLE)
        else $error("unselected strobe not deselecting");
    a_snooze_exit: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (snoozing_o && !snooze_req_i) ##1 !snooze_req_i |=> !snoozing_o)
        else $error("snooze not left in two clocks");
endmodule
`default_nettype wire

/* src/sbsc_pkg.sv */
// Shared constants for the synchronous burst SRAM cycle control block.
// Assumes one clock, no bus; all controls are plain ports.
package sbsc_pkg;
    localparam int          SBSC_ADDR_W   = 17;
    localparam int          SBSC_DATA_W   = 16;
    localparam int          SBSC_PAR_W    = 2;
    localparam int          SBSC_DEPTH    = 131072;
    localparam int          SBSC_CNT_W    = 2;
    localparam int          SBSC_SNZ_CLKS = 2;
    localparam logic [1:0]  SBSC_CNT_RST  = 2'h0;
    localparam logic [16:0] SBSC_ADDR_RST = 17'h0_0000;
    localparam logic [1:0]  SBSC_SNZ_RST  = 2'h0;
    localparam int          SBSC_LANE0_LO = 0;
    localparam int          SBSC_LANE1_LO = 8;
    localparam int          SBSC_LANE_W   = 8;

    typedef enum logic [1:0] {
        SBSC_IDLE  = 2'b00,
        SBSC_READ  = 2'b01,
        SBSC_WRITE = 2'b10
    } sbsc_cyc_t;
endpackage
